// >>> shared/rre_pkg.sv
package rre_pkg;
    // Widths of the core datapath
    localparam int RRE_DATA_W = 8;
    localparam int RRE_PC_W = 15;
    localparam int RRE_FADDR_W = 7;
    localparam int RRE_OP_W = 2;

    // Operation codes presented by the decode stage
    localparam logic [1:0] RRE_OP_SUB_RETURN = 2'h0;
    localparam logic [1:0] RRE_OP_INTERRUPT_RETURN = 2'h1;
    localparam logic [1:0] RRE_OP_LITERAL_RETURN = 2'h2;
    localparam logic [1:0] RRE_OP_ROTATE_LEFT_CARRY = 2'h3;

    // Destination select of the rotate
    localparam logic RRE_DEST_ACCUM = 1'b0;
    localparam logic RRE_DEST_FILE = 1'b1;

    // Field positions
    localparam int RRE_GIE_BIT = 7;
    localparam int RRE_MSB_BIT = 7;
    localparam int RRE_CARRY_BIT = 0;
    localparam int RRE_BUSY_BIT = 1;

    // APB register byte offsets
    localparam logic [7:0] RRE_ADDR_INTCTRL = 8'h00;
    localparam logic [7:0] RRE_ADDR_STATUS = 8'h04;
    localparam logic [7:0] RRE_ADDR_ACCUM = 8'h08;
    localparam logic [7:0] RRE_ADDR_PC = 8'h0C;

    // Reset values
    localparam logic [7:0] RRE_ACCUM_RST = 8'h00;
    localparam logic [14:0] RRE_PC_RST = 15'h0000;
    localparam logic RRE_CARRY_RST = 1'b0;
    localparam logic RRE_GIE_RST = 1'b0;
    localparam logic [31:0] RRE_WORD_ZERO = 32'h00000000;

    // Execution states
    typedef enum logic [0:0] {
        RRE_ST_IDLE,
        RRE_ST_FLUSH
    } rre_state_t;
endpackage : rre_pkg

// >>> hdl/rre_exec.sv
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rre_exec
    import rre_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Operation from decode
    input wire logic i_op_valid,
    input wire logic [RRE_OP_W-1:0] i_op_code,
    input wire logic [RRE_DATA_W-1:0] i_literal,
    input wire logic [RRE_FADDR_W-1:0] i_file_addr,
    input wire logic i_dest_sel,
    input wire logic [RRE_DATA_W-1:0] i_operand_data,
    output logic o_op_ready,
    output logic o_op_done,
    // Return stack
    input wire logic [RRE_PC_W-1:0] i_stack_top_entry,
    output logic o_stack_pop,
    // File register write port
    output logic o_file_wr_en,
    output logic [RRE_FADDR_W-1:0] o_file_wr_addr,
    output logic [RRE_DATA_W-1:0] o_file_wr_data,
    // Core state
    output logic [RRE_PC_W-1:0] o_pc,
    output logic [RRE_DATA_W-1:0] o_accum,
    output logic o_carry,
    output logic o_global_irq_enable_bit,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr
);

    rre_state_t state_reg;
    rre_state_t state_next;
    logic ready_reg;
    logic done_reg;
    logic pop_reg;
    logic wr_en_reg;
    logic [RRE_FADDR_W-1:0] wr_addr_reg;
    logic [RRE_DATA_W-1:0] wr_data_reg;
    logic [RRE_PC_W-1:0] pc_reg;
    logic [RRE_DATA_W-1:0] accum_reg;
    logic carry_reg;
    logic gie_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic op_taken;
    logic is_return;
    logic is_irq_return;
    logic is_lit_return;
    logic is_rotate;
    logic [RRE_DATA_W-1:0] rot_result;
    logic rot_carry_out;
    logic apb_write;

    // Address decode for the error response, shared by reads and writes
    function automatic logic addr_mapped(input logic [7:0] addr);
        addr_mapped = (addr == RRE_ADDR_INTCTRL) || (addr == RRE_ADDR_STATUS) ||
                      (addr == RRE_ADDR_ACCUM) || (addr == RRE_ADDR_PC);
    endfunction : addr_mapped

    // Operation decode
    assign op_taken = i_op_valid && ready_reg;
    assign is_irq_return = op_taken && (i_op_code == RRE_OP_INTERRUPT_RETURN);
    assign is_lit_return = op_taken && (i_op_code == RRE_OP_LITERAL_RETURN);
    assign is_return = is_irq_return || is_lit_return ||
                       (op_taken && (i_op_code == RRE_OP_SUB_RETURN));
    assign is_rotate = op_taken && (i_op_code == RRE_OP_ROTATE_LEFT_CARRY);
    assign apb_write = i_psel && i_penable && pready_reg && i_pwrite;

    // Rotate through carry
    assign rot_result = {i_operand_data[RRE_DATA_W-2:0], carry_reg};
    assign rot_carry_out = i_operand_data[RRE_MSB_BIT];

    // Returns spend a second cycle flushing the fetched successor
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RRE_ST_IDLE: begin
                if (is_return) begin
                    state_next = RRE_ST_FLUSH;
                end
            end
            RRE_ST_FLUSH: begin
                state_next = RRE_ST_IDLE;
            end
        endcase
    end

    // Sequencer: ready drops for the flush cycle, done marks completion
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= RRE_ST_IDLE;
            ready_reg <= 1'b1;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ready_reg <= (state_next == RRE_ST_IDLE);
            done_reg <= is_rotate || (state_reg == RRE_ST_FLUSH);
        end
    end

    // Program counter and stack pop
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pc_reg <= RRE_PC_RST;
            pop_reg <= 1'b0;
        end else begin
            pop_reg <= is_return;
            if (is_return) begin
                pc_reg <= i_stack_top_entry;
            end
        end
    end

    // Accumulator: hardware wins over a same-cycle software write
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            accum_reg <= RRE_ACCUM_RST;
        end else if (is_lit_return) begin
            accum_reg <= i_literal;
        end else if (is_rotate && (i_dest_sel == RRE_DEST_ACCUM)) begin
            accum_reg <= rot_result;
        end else if (apb_write && (i_paddr == RRE_ADDR_ACCUM)) begin
            accum_reg <= i_pwdata[RRE_DATA_W-1:0];
        end
    end

    // Carry: the rotate or a bus write to STATUS changes it; returns leave it alone
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            carry_reg <= RRE_CARRY_RST;
        end else if (is_rotate) begin
            carry_reg <= rot_carry_out;
        end else if (apb_write && (i_paddr == RRE_ADDR_STATUS)) begin
            carry_reg <= i_pwdata[RRE_CARRY_BIT];
        end
    end

    // Global interrupt enable: set by interrupt return beats a software clear
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gie_reg <= RRE_GIE_RST;
        end else if (is_irq_return) begin
            gie_reg <= 1'b1;
        end else if (apb_write && (i_paddr == RRE_ADDR_INTCTRL)) begin
            gie_reg <= i_pwdata[RRE_GIE_BIT];
        end
    end

    // File write-back, one-cycle strobe
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_en_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_data_reg <= '0;
        end else begin
            wr_en_reg <= is_rotate && (i_dest_sel == RRE_DEST_FILE);
            if (is_rotate) begin
                wr_addr_reg <= i_file_addr;
                wr_data_reg <= rot_result;
            end
        end
    end

    // APB: answer in the first access cycle; read data reflects state at setup
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= RRE_WORD_ZERO;
        end else begin
            pready_reg <= i_psel && !i_penable;
            pslverr_reg <= i_psel && !i_penable && !addr_mapped(i_paddr);
            if (i_psel && !i_penable) begin
                prdata_reg <= RRE_WORD_ZERO;
                unique case (i_paddr)
                    RRE_ADDR_INTCTRL: prdata_reg[RRE_GIE_BIT] <= gie_reg;
                    RRE_ADDR_STATUS: begin
                        prdata_reg[RRE_CARRY_BIT] <= carry_reg;
                        prdata_reg[RRE_BUSY_BIT] <= !ready_reg;
                    end
                    RRE_ADDR_ACCUM: prdata_reg[RRE_DATA_W-1:0] <= accum_reg;
                    RRE_ADDR_PC: prdata_reg[RRE_PC_W-1:0] <= pc_reg;
                    default: prdata_reg <= RRE_WORD_ZERO; // Unmapped reads zero
                endcase
            end
        end
    end

    // Outputs straight from flops
    assign o_op_ready = ready_reg;
    assign o_op_done = done_reg;
    assign o_stack_pop = pop_reg;
    assign o_file_wr_en = wr_en_reg;
    assign o_file_wr_addr = wr_addr_reg;
    assign o_file_wr_data = wr_data_reg;
    assign o_pc = pc_reg;
    assign o_accum = accum_reg;
    assign o_carry = carry_reg;
    assign o_global_irq_enable_bit = gie_reg;
    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;

    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence seq_ret_taken;
        is_return;
    endsequence

    sequence seq_two_cycle_tail;
        !o_op_ready && !o_op_done ##1 o_op_ready && o_op_done;
    endsequence

    AST_RET_PC_LOAD: assert property (
        seq_ret_taken |=> (o_pc == $past(i_stack_top_entry)) && o_stack_pop
    ) else $error("return did not load pc from stack top");

    AST_RET_FLAGS_KEPT: assert property (
        seq_ret_taken |=> $stable(o_carry) ##1 $stable(o_carry)
    ) else $error("return changed carry");

    AST_IRQ_RET_GIE: assert property (
        is_irq_return |=> o_global_irq_enable_bit
    ) else $error("interrupt return did not set enable");

    AST_RET_TWO_CYCLES: assert property (
        seq_ret_taken |=> seq_two_cycle_tail
    ) else $error("return did not take two cycles");

    AST_LIT_ACCUM: assert property (
        is_lit_return |=> (o_accum == $past(i_literal))
    ) else $error("literal not loaded into accumulator");

    AST_LIT_POP: assert property (
        is_lit_return |=> o_stack_pop ##1 !o_stack_pop && o_op_done
    ) else $error("literal return pop or length wrong");

    AST_ROT_DEST_ACC: assert property (
        is_rotate && (i_dest_sel == RRE_DEST_ACCUM) |=>
            (o_accum == $past(rot_result)) && !o_file_wr_en && o_op_done
    ) else $error("rotate to accumulator wrong");

    AST_ROT_DEST_FILE: assert property (
        is_rotate && (i_dest_sel == RRE_DEST_FILE) |=> o_file_wr_en &&
            (o_file_wr_addr == $past(i_file_addr)) && (o_file_wr_data == $past(rot_result))
            && $stable(o_accum)
    ) else $error("rotate to file wrong");

    AST_ROT_CARRY: assert property (
        is_rotate |=> (o_carry == $past(rot_carry_out)) && $stable(o_pc)
    ) else $error("rotate carry wrong");

    // A second pop for one return would lose a stack level the caller still owns
    AST_POP_ONE_PULSE: assert property (
        o_stack_pop |=> !o_stack_pop
    ) else $error("stack popped twice for one return");

    AST_FLUSH_REFUSE: assert property (
        !o_op_ready && i_op_valid |=> !o_stack_pop && $stable(o_pc)
    ) else $error("operation taken during flush cycle");

    AST_RET_NO_FILE_WRITE: assert property (
        seq_ret_taken |=> !o_file_wr_en
    ) else $error("return wrote the file register");

    AST_ROT_SINGLE_CYCLE: assert property (
        is_rotate |=> !o_stack_pop && o_op_ready
    ) else $error("rotate did not finish in one cycle");

    // Bus timing: zero wait states, error only for holes in the map
    AST_APB_ZERO_WAIT: assert property (
        i_psel && !i_penable |=> o_pready
    ) else $error("bus answer not in first access cycle");

    AST_APB_PREADY_PULSE: assert property (
        o_pready |=> !o_pready
    ) else $error("bus ready stood longer than one cycle");

    AST_APB_UNMAPPED_ERR: assert property (
        i_psel && !i_penable && (i_paddr > RRE_ADDR_PC) |=> o_pslverr
    ) else $error("unmapped access not flagged");

endmodule : rre_exec
`default_nettype wire

// >>> bench/rre_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rre_pkg::*;
    // Stimulus and observed signals
    logic i_clock, i_rst_n, i_op_valid, i_dest_sel, i_psel, i_penable, i_pwrite;
    logic [1:0] i_op_code;
    logic [7:0] i_literal, i_operand_data, i_paddr, o_file_wr_data, o_accum;
    logic [6:0] i_file_addr, o_file_wr_addr;
    logic [14:0] i_stack_top_entry, o_pc;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic o_op_ready, o_op_done, o_stack_pop, o_file_wr_en, o_carry;
    logic o_global_irq_enable_bit, o_pready, o_pslverr, er;
    int err_count = 0;
    int samples_checked = 0;

    rre_exec dut (.i_clock, .i_rst_n, .i_op_valid, .i_op_code, .i_literal, .i_file_addr,
        .i_dest_sel, .i_operand_data, .o_op_ready, .o_op_done, .i_stack_top_entry,
        .o_stack_pop, .o_file_wr_en, .o_file_wr_addr, .o_file_wr_data, .o_pc, .o_accum,
        .o_carry, .o_global_irq_enable_bit, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .o_prdata, .o_pready, .o_pslverr);

    // 100 MHz clock
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // Counts the comparison; four-state match so an unknown never passes
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // One APB transfer; request held until pready is seen, bounded wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rdat, output logic err);
        int n;
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        // Request stands until the edge that samples pready high; data taken there
        for (n = 0; n < 20; n++) begin
            @(posedge i_clock);
            if (o_pready === 1'b1) break;
        end
        if (n == 20) begin
            err_count++;
            complete_run();
        end
        rdat = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    // Accumulator round trip over the bus, then carry preset for the returns
    task automatic reg_rw_scn();
        apb(1'b1, RRE_ADDR_ACCUM, 32'h0000003C, rd, er);
        apb(1'b0, RRE_ADDR_ACCUM, 32'h00000000, rd, er);
        chk("accum reg", 32'h0000003C, rd);
        chk("mapped err", 0, er);
        apb(1'b1, RRE_ADDR_STATUS, 32'h00000001, rd, er);
    endtask : reg_rw_scn

    // Register map after the returns: enable set, carry kept, pc read-only, hole flagged
    task automatic reg_map_scn();
        apb(1'b0, RRE_ADDR_INTCTRL, 32'h00000000, rd, er);
        chk("intctrl", 32'h00000080, rd);
        apb(1'b0, RRE_ADDR_STATUS, 32'h00000000, rd, er);
        chk("status", 32'h00000001, rd);
        apb(1'b1, RRE_ADDR_PC, 32'h00000055, rd, er);
        apb(1'b0, RRE_ADDR_PC, 32'h00000000, rd, er);
        chk("pc reg", 32'h00000001, rd);
        apb(1'b0, 8'h10, 32'h00000000, rd, er);
        chk("unmapped err", 1, er);
        chk("unmapped data", 0, rd);
        apb(1'b1, RRE_ADDR_STATUS, 32'h00000000, rd, er);
    endtask : reg_map_scn

    // Return: stack value is scrambled after the take edge, as a real stack pops
    task automatic ret_op(input logic [1:0] code, input logic [14:0] stack_top_entry, input logic [7:0] lit,
                          input logic [7:0] acc_exp, input logic gie_exp, input logic c_exp);
        @(posedge i_clock);
        i_op_valid <= 1'b1;
        i_op_code <= code;
        i_literal <= lit;
        i_stack_top_entry <= stack_top_entry;
        @(posedge i_clock);
        i_op_code <= RRE_OP_ROTATE_LEFT_CARRY; // Offered in the flush cycle, must be refused
        i_stack_top_entry <= ~stack_top_entry;
        #1;
        chk("pc", stack_top_entry, o_pc);
        chk("pop", 1, o_stack_pop);
        chk("ready", 0, o_op_ready);
        chk("done early", 0, o_op_done);
        @(posedge i_clock);
        i_op_valid <= 1'b0;
        #1;
        chk("done", 1, o_op_done);
        chk("pop end", 0, o_stack_pop);
        chk("pc held", stack_top_entry, o_pc);
        chk("accum", acc_exp, o_accum);
        chk("gie", gie_exp, o_global_irq_enable_bit);
        chk("carry", c_exp, o_carry);
    endtask : ret_op

    // Rotate: single cycle, result either in accumulator or file write
    task automatic rot_op(input logic [6:0] fa, input logic [7:0] opd, input logic d,
                          input logic [7:0] res, input logic c_exp, input logic [7:0] acc_exp);
        @(posedge i_clock);
        i_op_valid <= 1'b1;
        i_op_code <= RRE_OP_ROTATE_LEFT_CARRY;
        i_file_addr <= fa;
        i_operand_data <= opd;
        i_dest_sel <= d;
        @(posedge i_clock);
        i_op_valid <= 1'b0;
        #1;
        chk("rot done", 1, o_op_done);
        chk("rot carry", c_exp, o_carry);
        chk("rot accum", acc_exp, o_accum);
        chk("wr en", d, o_file_wr_en);
        if (d) begin
            chk("wr addr", fa, o_file_wr_addr);
            chk("wr data", res, o_file_wr_data);
        end
        @(posedge i_clock);
        #1;
        chk("wr end", 0, o_file_wr_en);
    endtask : rot_op

    // Main sequence
    initial begin
        {i_rst_n, i_op_valid, i_dest_sel, i_psel, i_penable, i_pwrite, i_op_code} = '0;
        {i_literal, i_operand_data, i_paddr, i_file_addr, i_stack_top_entry, i_pwdata} = '0;
        repeat (16) @(posedge i_clock);
        chk("rst pc", 0, o_pc);
        chk("rst ready", 1, o_op_ready);
        i_rst_n <= 1'b1;
        reg_rw_scn();
        ret_op(RRE_OP_SUB_RETURN, 15'h1234, 8'h00, 8'h3C, 1'b0, 1'b1);
        ret_op(RRE_OP_LITERAL_RETURN, 15'h7FFF, 8'hFF, 8'hFF, 1'b0, 1'b1);
        ret_op(RRE_OP_INTERRUPT_RETURN, 15'h0001, 8'h5A, 8'hFF, 1'b1, 1'b1);
        reg_map_scn();
        rot_op(7'h7F, 8'hE6, RRE_DEST_ACCUM, 8'hCC, 1'b1, 8'hCC);
        rot_op(7'h00, 8'h35, RRE_DEST_FILE, 8'h6B, 1'b0, 8'hCC);
        complete_run();
    end
endmodule : tb
`default_nettype wire
